// File: adc_front_defines.svh
// timing-free constants for the converter front-end control block
`ifndef ADC_FRONT_DEFINES_SVH
`define ADC_FRONT_DEFINES_SVH
// ------------------------------------------------------------
// field widths and positions
// ------------------------------------------------------------
`define CHAN_FIELD_W 4
`define PAIR_CFG_W 4
`define GAIN_FIELD_W 3
`define TEMP_SEL_BIT 3
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define CHAN_RESET 4'h0
`define PAIR_CFG_RESET 4'h0
`define GAIN_RESET 3'h0
`define ENABLE_RESET 1'b0
// ------------------------------------------------------------
// gain codes
// ------------------------------------------------------------
`define GAIN_CODE_X1 3'h0
`define GAIN_CODE_X2 3'h1
`define GAIN_CODE_X4 3'h2
`define GAIN_CODE_X8 3'h3
`define GAIN_CODE_X16 3'h4
`define GAIN_CODE_XHALF 3'h6
// ------------------------------------------------------------
// one-hot positions for the nine routes
// ------------------------------------------------------------
`define ROUTE_W 9
`define ROUTE_TEMP 8
`endif

// File: adc_front_pkg.sv
// types shared by the converter front-end control block
package adc_front_pkg;
  // decoded gain setting
  typedef enum logic [2:0] {
    gain_x1, gain_x2, gain_x4, gain_x8, gain_x16, gain_xhalf
  } gain_e;
  // power state of the analog subsystem
  typedef enum logic {
    pwr_shutdown, pwr_active
  } pwr_e;
endpackage : adc_front_pkg

// File: input_route_decode.sv
// combinational route decode for the analog input selector
`timescale 1ns/100ps
`include "adc_front_defines.svh"
module input_route_decode
  import adc_front_pkg::*;
(
  input wire logic [3:0] i_chan, // channel select field
  input wire logic [3:0] i_pair_cfg, // one bit per input pair
  output logic [8:0] o_pos_route, // one-hot positive leg
  output logic [7:0] o_neg_route, // negative leg, zero when single-ended
  output logic o_diff // selected channel is differential
);
  // ------------------------------------------------------------
  // route decode
  // ------------------------------------------------------------
  logic [1:0] pair_idx; // which pair the selected input belongs to
  logic pair_diff; // that pair is in differential mode
  assign pair_idx = i_chan[2:1];
  assign pair_diff = i_pair_cfg[pair_idx];
  // decode the selector; temperature sensor wins on top bit
  always_comb begin
    o_pos_route = 9'h000;
    o_neg_route = 8'h00;
    o_diff = 1'b0;
    if (i_chan[`TEMP_SEL_BIT]) begin
      o_pos_route[`ROUTE_TEMP] = 1'b1;
    end else if (pair_diff) begin
      // both codes of a pair reach the same even+/odd- pair
      o_pos_route[{pair_idx, 1'b0}] = 1'b1;
      o_neg_route[{pair_idx, 1'b1}] = 1'b1;
      o_diff = 1'b1;
    end else begin
      o_pos_route[i_chan[2:0]] = 1'b1;
    end
  end
endmodule : input_route_decode

// File: adc_input_select_gain_ctrl.sv
// top of the converter front-end control: enable, selector and gain
`timescale 1ns/100ps
`include "adc_front_defines.svh"
module adc_input_select_gain_ctrl
  import adc_front_pkg::*;
(
  input wire logic i_clk_sys, // system clock, 50 MHz
  input wire logic i_rst, // synchronous reset, active high
  input wire logic i_subsystem_enable, // software enable bit
  input wire logic [3:0] i_channel_select_field, // channel code
  input wire logic [3:0] i_input_pair_config, // pair mode bits
  input wire logic [2:0] i_gain_select_field, // gain code
  output logic o_converter_en, // converter core enable
  output logic o_track_hold_en, // track-and-hold enable
  output logic o_gain_stage_en, // gain stage enable
  output logic [8:0] o_pos_route, // positive leg one-hot
  output logic [7:0] o_neg_route, // negative leg one-hot, all zero unless differential
  output logic o_twos_complement, // result format flag
  output gain_e o_gain, // decoded gain
  output logic [3:0] o_pair_config // readback of pair modes
);
  // ------------------------------------------------------------
  // configuration state
  // ------------------------------------------------------------
  logic enable; // registered subsystem enable
  logic next_enable;
  logic [3:0] chan; // registered channel code
  logic [3:0] next_chan;
  logic [3:0] pair_cfg; // registered pair modes
  logic [3:0] next_pair_cfg;
  logic [2:0] gain_code; // registered gain code
  logic [2:0] next_gain_code;
  logic [8:0] pos_dec; // decoder outputs
  logic [7:0] neg_dec;
  logic diff_dec;
  gain_e gain_dec; // decoded gain
  pwr_e pwr; // power state seen by the analog side

  // map gain code to setting; unused codes fall back to unity
  function automatic gain_e decode_gain(input logic [2:0] code);
    case (code)
      `GAIN_CODE_X1: decode_gain = gain_x1;
      `GAIN_CODE_X2: decode_gain = gain_x2;
      `GAIN_CODE_X4: decode_gain = gain_x4;
      `GAIN_CODE_X8: decode_gain = gain_x8;
      `GAIN_CODE_X16: decode_gain = gain_x16;
      `GAIN_CODE_XHALF: decode_gain = gain_xhalf;
      default: decode_gain = gain_x1;
    endcase
  endfunction : decode_gain

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  // settings follow software every cycle, so a change applies live
  always_comb begin
    next_enable = i_subsystem_enable;
    next_chan = i_channel_select_field;
    next_pair_cfg = i_input_pair_config;
    next_gain_code = i_gain_select_field;
  end

  // registers; reset gives disabled, single-ended, unity gain
  // software may rewrite any field on any cycle; nothing here waits for idle,
  // so a mode change never needs a reset or a disable first
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      enable <= `ENABLE_RESET;
      chan <= `CHAN_RESET;
      pair_cfg <= `PAIR_CFG_RESET;
      gain_code <= `GAIN_RESET;
    end else begin
      enable <= next_enable;
      chan <= next_chan;
      pair_cfg <= next_pair_cfg;
      gain_code <= next_gain_code;
    end
  end

  // ------------------------------------------------------------
  // route decode
  // ------------------------------------------------------------
  // the decoder sees only registered settings, so routes move one clock
  // after software, in step with the enables
  input_route_decode u_route (
    .i_chan(chan),
    .i_pair_cfg(pair_cfg),
    .o_pos_route(pos_dec),
    .o_neg_route(neg_dec),
    .o_diff(diff_dec)
  );

  // spare gain codes decode to unity inside the function
  assign gain_dec = decode_gain(gain_code);
  // one power state drives all three enables, so they cannot disagree
  assign pwr = enable ? pwr_active : pwr_shutdown;

  // outputs come from flip-flop state through thin decode only;
  // a second register stage would delay enables for no benefit
  always_comb begin
    o_converter_en = (pwr == pwr_active);
    o_track_hold_en = (pwr == pwr_active);
    o_gain_stage_en = (pwr == pwr_active);
    o_pos_route = pos_dec;
    o_neg_route = neg_dec;
    o_twos_complement = diff_dec;
    o_gain = gain_dec;
    o_pair_config = pair_cfg;
  end

  // ------------------------------------------------------------
  // checks: power
  // ------------------------------------------------------------
  // the edge after any reset is skipped: registers then still hold reset
  // values, not what software drove while reset was high
  chk_enable_follow: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !$past(i_rst) |->
    (o_converter_en && o_track_hold_en && o_gain_stage_en) == $past(i_subsystem_enable))
    else $error("enables do not follow subsystem enable");
  // a half-powered chain still draws current, so all three must drop
  chk_shutdown_all: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !$past(i_rst) && !$past(i_subsystem_enable) |->
    !o_converter_en && !o_track_hold_en && !o_gain_stage_en)
    else $error("part of the chain left on in shutdown");

  // ------------------------------------------------------------
  // checks: routing
  // ------------------------------------------------------------
  // any code with the top bit set reaches the sensor, whatever the pairs say
  chk_temp_route: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !$past(i_rst) && $past(i_channel_select_field[3]) |->
    o_pos_route == 9'h100 && o_neg_route == 8'h00 && !o_twos_complement)
    else $error("temperature sensor not routed");
  chk_temp_alone: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_pos_route[8] |-> o_neg_route == 8'h00 && !o_twos_complement)
    else $error("sensor route carries a minus leg");
  // exactly one of the nine routes is closed at any time
  chk_nine_onehot: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $onehot(o_pos_route))
    else $error("positive route not one-hot");
  // both codes of a differential pair land on the same even/odd legs
  chk_diff_pair: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !$past(i_rst) && !$past(i_channel_select_field[3]) &&
    $past(i_input_pair_config[i_channel_select_field[2:1]]) |->
    o_pos_route == (9'h001 << {$past(i_channel_select_field[2:1]), 1'b0}) &&
    o_neg_route == (8'h02 << {$past(i_channel_select_field[2:1]), 1'b0}))
    else $error("differential legs wrong");
  chk_neg_odd: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (o_neg_route & 8'h55) == 8'h00)
    else $error("minus leg on an even input");
  chk_diff_even_plus: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_twos_complement |-> (o_pos_route & 9'h0AA) == 9'h000)
    else $error("plus leg on an odd input");
  // single-ended: the code picks its own input and the minus leg stays open
  chk_single_route: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !$past(i_rst) && !$past(i_channel_select_field[3]) &&
    !$past(i_input_pair_config[i_channel_select_field[2:1]]) |->
    o_pos_route == (9'h001 << $past(i_channel_select_field[2:0])) && o_neg_route == 8'h00)
    else $error("single-ended route wrong");
  chk_single_neg: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (o_neg_route == 8'h00) == !o_twos_complement)
    else $error("format flag disagrees with route");
  chk_diff_format: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !$past(i_rst) && !$past(i_channel_select_field[3]) |->
    o_twos_complement == $past(i_input_pair_config[i_channel_select_field[2:1]]))
    else $error("result format does not follow pair mode");
  // pair modes follow software a clock later with no reset or disable
  chk_live_change: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !$past(i_rst) |-> o_pair_config == $past(i_input_pair_config))
    else $error("pair config not applied next cycle");
  // reset leaves every pair single-ended and the plain route on input 0
  chk_reset_state: assert property (@(posedge i_clk_sys)
    $past(i_rst) |-> o_pair_config == 4'h0 && o_gain == gain_x1 && !o_converter_en)
    else $error("reset values wrong");
  chk_reset_route: assert property (@(posedge i_clk_sys)
    $past(i_rst) |-> o_pos_route == 9'h001 && o_neg_route == 8'h00 && !o_twos_complement)
    else $error("reset route not single-ended input 0");

  // ------------------------------------------------------------
  // checks: gain
  // ------------------------------------------------------------
  chk_gain_map: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !$past(i_rst) && $past(i_gain_select_field) == 3'h4 |-> o_gain == gain_x16)
    else $error("gain code not decoded");
  // codes one to three step the gain by powers of two
  chk_gain_steps: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !$past(i_rst) |->
    ($past(i_gain_select_field) != `GAIN_CODE_X2 || o_gain == gain_x2) &&
    ($past(i_gain_select_field) != `GAIN_CODE_X4 || o_gain == gain_x4) &&
    ($past(i_gain_select_field) != `GAIN_CODE_X8 || o_gain == gain_x8))
    else $error("power-of-two gain code not decoded");
  // spare codes fall back to unity rather than leaving the stage undefined
  chk_gain_unused: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !$past(i_rst) &&
    ($past(i_gain_select_field) == 3'h5 || $past(i_gain_select_field) == 3'h7) |->
    o_gain == gain_x1)
    else $error("spare gain code not unity");
  chk_gain_reset: assert property (@(posedge i_clk_sys)
    $past(i_rst) |-> o_gain == gain_x1)
    else $error("reset gain not unity");
  chk_gain_distinct: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !$past(i_rst) && $past(i_gain_select_field) == 3'h6 |-> o_gain == gain_xhalf)
    else $error("half gain code wrong");

  // ------------------------------------------------------------
  // cover points
  // ------------------------------------------------------------
  // main scenarios the bench is expected to reach
  cov_temp: cover property (@(posedge i_clk_sys) o_pos_route[8]);
  cov_diff: cover property (@(posedge i_clk_sys) o_twos_complement);
  cov_enable: cover property (@(posedge i_clk_sys) $rose(o_converter_en));
  cov_live: cover property (@(posedge i_clk_sys) o_converter_en && $changed(o_pair_config));
  cov_half_gain: cover property (@(posedge i_clk_sys) o_gain == gain_xhalf);
endmodule : adc_input_select_gain_ctrl

// File: analog_core_model.sv
// behavioural model of the analog selector, gain stage and converter core
`timescale 1ns/100ps
module analog_core_model
  import adc_front_pkg::*;
(
  input wire logic i_converter_en, // core enable
  input wire logic i_track_hold_en, // track-and-hold enable
  input wire logic i_gain_stage_en, // gain stage enable
  input wire logic [8:0] i_pos_route, // positive leg switches
  input wire logic [7:0] i_neg_route, // negative leg switches
  output logic o_powered, // whole chain awake
  output logic o_route_bad // switch pattern that would short inputs
);
  // ------------------------------------------------------------
  // power and switch sanity
  // ------------------------------------------------------------
  // a partly powered chain still draws current, so it counts as off
  always_comb begin
    o_powered = i_converter_en & i_track_hold_en & i_gain_stage_en;
    o_route_bad = ($countones(i_pos_route) != 1) || ($countones(i_neg_route) > 1);
  end
endmodule : analog_core_model

// File: tb.sv
// self-checking bench for the converter front-end control
`timescale 1ns/100ps
module tb
  import adc_front_pkg::*;
;
  // ------------------------------------------------------------
  // stimulus, observed outputs and counters
  // ------------------------------------------------------------
  logic i_clk_sys = 1'b0; // 50 MHz system clock
  logic i_rst = 1'b1; // reset held from time zero
  logic i_subsystem_enable = 1'b1; // set during reset to prove it is ignored
  logic [3:0] i_channel_select_field = 4'h5;
  logic [3:0] i_input_pair_config = 4'hF;
  logic [2:0] i_gain_select_field = 3'h4;
  logic o_converter_en, o_track_hold_en, o_gain_stage_en, o_twos_complement;
  logic [8:0] o_pos_route;
  logic [7:0] o_neg_route;
  logic [3:0] o_pair_config;
  gain_e o_gain;
  logic powered, route_bad; // from the far-side model
  int miscompares = 0;
  int cmp_count = 0;
  always #10 i_clk_sys = ~i_clk_sys;
  adc_input_select_gain_ctrl i_adc_input_select_gain_ctrl (.i_clk_sys, .i_rst,
    .i_subsystem_enable, .i_channel_select_field, .i_input_pair_config,
    .i_gain_select_field, .o_converter_en, .o_track_hold_en, .o_gain_stage_en,
    .o_pos_route, .o_neg_route, .o_twos_complement, .o_gain, .o_pair_config);
  analog_core_model i_analog_core_model (.i_converter_en(o_converter_en),
    .i_track_hold_en(o_track_hold_en), .i_gain_stage_en(o_gain_stage_en),
    .i_pos_route(o_pos_route), .i_neg_route(o_neg_route), .o_powered(powered),
    .o_route_bad(route_bad));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  // gain codes 5 and 7 are unused and fall back to unity
  function automatic gain_e exp_gain(input logic [2:0] g);
    case (g)
      3'h1: return gain_x2;
      3'h2: return gain_x4;
      3'h3: return gain_x8;
      3'h4: return gain_x16;
      3'h6: return gain_xhalf;
      default: return gain_x1;
    endcase
  endfunction : exp_gain
  // drive on one edge; the design samples it at the next and answers at once
  task automatic apply(input logic e, input logic [3:0] c, input logic [3:0] p,
                       input logic [2:0] g);
    @(posedge i_clk_sys);
    i_subsystem_enable <= e;
    i_channel_select_field <= c;
    i_input_pair_config <= p;
    i_gain_select_field <= g;
    @(posedge i_clk_sys);
    #1;
  endtask : apply
  task automatic check_all();
    logic [1:0] k;
    logic d;
    k = i_channel_select_field[2:1];
    d = !i_channel_select_field[3] && i_input_pair_config[k];
    chk({o_converter_en, o_track_hold_en, o_gain_stage_en}, {3{i_subsystem_enable}});
    chk(powered, i_subsystem_enable);
    chk(o_pos_route, i_channel_select_field[3] ? 9'h100 : d ? 9'h001 << {k, 1'b0}
        : 9'h001 << i_channel_select_field[2:0]);
    chk(o_neg_route, d ? 8'h01 << {k, 1'b1} : 8'h00);
    chk(o_twos_complement, d);
    chk(o_pair_config, i_input_pair_config);
    chk(o_gain, exp_gain(i_gain_select_field));
    chk(route_bad, 1'b0);
  endtask : check_all
  task automatic chk_reset();
    chk({o_converter_en, o_track_hold_en, o_gain_stage_en, o_twos_complement}, 9'h000);
    chk(o_pair_config, 4'h0);
    chk(o_pos_route, 9'h001);
    chk(o_neg_route, 8'h00);
    chk(o_gain, gain_x1);
  endtask : chk_reset
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  // pair sets 0, 5, A, F flip modes live under every channel code
  initial begin
    repeat (3) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    #1;
    chk_reset();
    @(posedge i_clk_sys);
    #1;
    check_all();
    for (int p = 0; p < 16; p += 5) begin
      for (int c = 0; c < 16; c++) begin
        apply(1'b1, c[3:0], p[3:0], 3'h0);
        check_all();
      end
    end
    // every gain code, enable toggling underneath
    for (int g = 0; g < 8; g++) begin
      apply(g[0], 4'h3, 4'h2, g[2:0]);
      check_all();
    end
    // second reset in mid-run with live settings applied
    @(posedge i_clk_sys);
    i_rst <= 1'b1;
    @(posedge i_clk_sys);
    #1;
    chk_reset();
    // release again: the settings still applied must return at once
    @(posedge i_clk_sys);
    i_rst <= 1'b0;
    @(posedge i_clk_sys);
    #1;
    check_all();
    wrap_up();
  end
  // watchdog well beyond the roughly 150 cycles the sequence needs
  initial begin
    #40000;
    miscompares++;
    wrap_up();
  end
endmodule : tb
